// [rtl/vpio_glue.v]
// Operation
// - four units, 8-bit input and output each
// - two handshake lines per port
// - each unit has interrupting 24-bit timer
// - all requests merge onto strapped level
// - four port vectors, one timer vector
// - units 0,1 low lane, 2,3 high
// - paired units share one common handshake
// - decode strapped base and address modifier
// - 512-byte window, up to 16-bit transfers
// - every unit register directly addressable
// bus-side glue: vme slave decode, lane mapping, interrupt merge
// assumes bus inputs synchronous to clk, straps static
`timescale 1ns/10ps
`include "vpio_map.vh"
module vpio_glue #(
  parameter NUNIT = 4,
  parameter TMR_W = 24
) (
  // clock and reset
  input wire clk,
  input wire resetn,
  // board straps
  input wire [23:9] base_addr,
  input wire a16_mode,
  input wire [2:0] irq_level,
  input wire pair_mode,
  // vme slave
  input wire [23:1] vme_addr,
  input wire [5:0] vme_am,
  input wire vme_as_n,
  input wire vme_ds0_n,
  input wire vme_ds1_n,
  input wire vme_write_n,
  input wire vme_iack_n,
  input wire [3:1] vme_iack_level,
  input wire [15:0] vme_data_in,
  output reg [15:0] vme_data_out,
  output wire vme_data_oe,
  output wire vme_dtack_n,
  output wire [7:1] vme_irq_n,
  // parallel ports
  input wire [8*NUNIT-1:0] in_data,
  input wire [NUNIT-1:0] in_hs_req,
  output wire [NUNIT-1:0] in_hs_ack,
  output wire [8*NUNIT-1:0] out_data,
  output wire [NUNIT-1:0] out_hs_req,
  input wire [NUNIT-1:0] out_hs_ack
);
  localparam ST_IDLE = 2'h0;
  localparam ST_WAIT = 2'h1;
  localparam ST_ACK = 2'h2;
  reg [1:0] state_r;
  reg [1:0] dly_r;
  reg data_oe_r;
  reg is_iack_r;
  reg [2:0] iack_unit_r;
  reg iack_tmr_r;
  reg [7:0] iack_vec_r;
  wire am_ok;
  wire addr_ok;
  wire sel;
  wire iack_hit;
  wire [NUNIT-1:0] wr_stb;
  wire [NUNIT-1:0] rd_stb;
  wire [8*NUNIT-1:0] unit_rdata;
  wire [NUNIT-1:0] port_irq;
  wire [NUNIT-1:0] tmr_irq;
  wire [2*NUNIT-1:0] port_src;
  wire [NUNIT-1:0] iack_port;
  wire [NUNIT-1:0] iack_tmr;
  wire [8*NUNIT-1:0] port_vec;
  wire [8*NUNIT-1:0] tmr_vec;
  wire [NUNIT-1:0] ext_strobe;
  wire any_irq;
  wire start;
  genvar g;
  integer k;
  ////////////////////////////////////////////////////////////////////////
  // address and modifier decode
  assign am_ok = a16_mode ? (vme_am == `VPIO_AM_A16_STD || vme_am == `VPIO_AM_A16_SUP)
                          : (vme_am == `VPIO_AM_A24_STD || vme_am == `VPIO_AM_A24_SUP);
  assign addr_ok = a16_mode ? (vme_addr[15:9] == base_addr[15:9])
                            : (vme_addr[23:9] == base_addr);
  assign sel = am_ok && addr_ok && vme_iack_n && !vme_as_n && !(vme_ds0_n && vme_ds1_n);
  assign iack_hit = !vme_iack_n && !vme_as_n && !vme_ds0_n && vme_iack_level == irq_level && any_irq;
  assign start = state_r == ST_IDLE && (sel || iack_hit);
  ////////////////////////////////////////////////////////////////////////
  // lane mapping: units 0,1 on d7..d0 via ds0, units 2,3 on d15..d8 via ds1
  generate
    for (g = 0; g < NUNIT; g = g + 1)
    begin : g_unit
      localparam [2:0] UNIT_ID = g;
      wire lane_hit;
      assign lane_hit = (g < NUNIT/2) ? !vme_ds0_n : !vme_ds1_n;
      assign wr_stb[g] = start && sel && !vme_write_n && lane_hit
                         && vme_addr[`VPIO_UNIT_SEL_LSB] == UNIT_ID[0];
      assign rd_stb[g] = start && sel && vme_write_n && lane_hit
                         && vme_addr[`VPIO_UNIT_SEL_LSB] == UNIT_ID[0];
      // one-cycle clear as the vector is loaded, so a held strobe clears one source only
      assign iack_port[g] = state_r == ST_WAIT && dly_r == 2'h1 && is_iack_r
                            && !iack_tmr_r && iack_unit_r == UNIT_ID;
      assign iack_tmr[g] = state_r == ST_WAIT && dly_r == 2'h1 && is_iack_r
                           && iack_tmr_r && iack_unit_r == UNIT_ID;
      // paired unit follows partner's output strobe
      if (g >= NUNIT/2)
      begin : g_hi
        assign ext_strobe[g] = pair_mode && wr_stb[g-NUNIT/2];
      end
      else
      begin : g_lo
        assign ext_strobe[g] = 1'b0;
      end
      vpio_unit #(
        .TMR_W(TMR_W)
      ) u_unit (
        .clk(clk),
        .resetn(resetn),
        .wr_stb(wr_stb[g]),
        .rd_stb(rd_stb[g]),
        .reg_sel(vme_addr[`VPIO_REG_LSB+`VPIO_REG_BITS-1:`VPIO_REG_LSB]),
        .wdata((g < NUNIT/2) ? vme_data_in[7:0] : vme_data_in[15:8]),
        .rdata(unit_rdata[8*g+7:8*g]),
        .in_data(in_data[8*g+7:8*g]),
        .in_hs_req(in_hs_req[g]),
        .in_hs_ack(in_hs_ack[g]),
        .out_data(out_data[8*g+7:8*g]),
        .out_hs_req(out_hs_req[g]),
        .out_hs_ack(out_hs_ack[g]),
        .ext_strobe(ext_strobe[g]),
        .port_irq(port_irq[g]),
        .tmr_irq(tmr_irq[g]),
        .port_src(port_src[2*g+1:2*g]),
        .iack_port(iack_port[g]),
        .iack_tmr(iack_tmr[g]),
        .port_vec(port_vec[8*g+7:8*g]),
        .tmr_vec(tmr_vec[8*g+7:8*g])
      );
    end
  endgenerate
  ////////////////////////////////////////////////////////////////////////
  // interrupt merge onto strapped level
  assign any_irq = |{port_irq, tmr_irq};
  generate
    for (g = 1; g < 8; g = g + 1)
    begin : g_irq
      localparam [2:0] LVL_ID = g;
      assign vme_irq_n[g] = !(any_irq && irq_level == LVL_ID);
    end
  endgenerate
  ////////////////////////////////////////////////////////////////////////
  // slave cycle sequencer
  assign vme_dtack_n = !(state_r == ST_ACK);
  assign vme_data_oe = data_oe_r;
  always @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      state_r <= ST_IDLE;
      dly_r <= 2'h0;
      data_oe_r <= 1'b0;
      is_iack_r <= 1'b0;
      iack_unit_r <= 3'h0;
      iack_tmr_r <= 1'b0;
      iack_vec_r <= 8'h00;
      vme_data_out <= 16'h0000;
    end
    else
    begin
      case (state_r)
        ST_IDLE:
        begin
          if (start)
          begin
            state_r <= ST_WAIT;
            dly_r <= `VPIO_DTACK_DLY;
            is_iack_r <= iack_hit;
            data_oe_r <= iack_hit || vme_write_n;
            iack_tmr_r <= 1'b0;
            iack_unit_r <= 3'h0;
            iack_vec_r <= 8'h00;
            // lowest unit first; port before timer within a unit
            for (k = NUNIT - 1; k >= 0; k = k - 1)
            begin
              if (tmr_irq[k])
              begin
                iack_unit_r <= k[2:0];
                iack_tmr_r <= 1'b1;
                iack_vec_r <= tmr_vec[8*k+:8];
              end
              if (port_irq[k])
              begin
                iack_unit_r <= k[2:0];
                iack_tmr_r <= 1'b0;
                iack_vec_r <= port_vec[8*k+:8];
              end
            end
          end
        end
        ST_WAIT:
        begin
          if (dly_r == 2'h1)
          begin
            state_r <= ST_ACK;
            if (is_iack_r)
              vme_data_out <= {8'h00, iack_vec_r};
            else
              vme_data_out <= {unit_rdata[8*NUNIT/2+8*(vme_addr[`VPIO_UNIT_SEL_LSB] ? 1 : 0)+:8],
                               unit_rdata[8*(vme_addr[`VPIO_UNIT_SEL_LSB] ? 1 : 0)+:8]};
          end
          dly_r <= dly_r - 2'h1;
        end
        ST_ACK:
        begin
          if (vme_as_n || (vme_ds0_n && vme_ds1_n))
          begin
            state_r <= ST_IDLE;
            data_oe_r <= 1'b0;
            is_iack_r <= 1'b0;
          end
        end
        default:
          state_r <= ST_IDLE;
      endcase
    end
  end
endmodule

// [pkg/vpio_map.vh]
// constants for the bus-side glue of the four-unit parallel i/o board
// assumes a vme-style slave handshake sampled on clk
`ifndef VPIO_MAP_VH
`define VPIO_MAP_VH
`define VPIO_AM_A24_STD 6'h39
`define VPIO_AM_A24_SUP 6'h3D
`define VPIO_AM_A16_STD 6'h29
`define VPIO_AM_A16_SUP 6'h2D
`define VPIO_WIN_BITS 9
`define VPIO_UNIT_SEL_LSB 7
`define VPIO_REG_LSB 1
`define VPIO_REG_BITS 6
`define VPIO_VEC_RST 8'h0F
`define VPIO_TMR_BITS 24
`define VPIO_CTL_TMR_EN 0
`define VPIO_CTL_OUT_HS 1
`define VPIO_DTACK_DLY 2'h2
`endif

// [rtl/vpio_unit.v]
// one parallel interface and timer unit: 8-bit in and out port, 24-bit timer, vectors
// assumes register accesses arrive as single-cycle strobes
`timescale 1ns/10ps
`include "vpio_map.vh"
module vpio_unit #(
  parameter TMR_W = 24
) (
  // clock and reset
  input wire clk,
  input wire resetn,
  // register strobes
  input wire wr_stb,
  input wire rd_stb,
  input wire [5:0] reg_sel,
  input wire [7:0] wdata,
  output reg [7:0] rdata,
  // external input port
  input wire [7:0] in_data,
  input wire in_hs_req,
  output reg in_hs_ack,
  // external output port
  output reg [7:0] out_data,
  output reg out_hs_req,
  input wire out_hs_ack,
  // shared-handshake control
  input wire ext_strobe,
  // interrupts
  output wire port_irq,
  output wire tmr_irq,
  output wire [1:0] port_src,
  input wire iack_port,
  input wire iack_tmr,
  output wire [7:0] port_vec,
  output wire [7:0] tmr_vec
);
  reg [7:0] ctl_r;
  reg [7:0] in_latch_r;
  reg [TMR_W-1:0] preload_r;
  reg [TMR_W-1:0] count_r;
  reg tmr_pend_r;
  reg [3:0] port_pend_r;
  reg [7:0] vec_r [0:4];
  reg in_req_d_r;
  reg out_ack_d_r;
  wire in_edge;
  wire out_done;
  wire tmr_zero;
  wire ctl_wr;
  wire [3:0] port_set;
  wire [3:0] port_clr;
  genvar g;
  integer i;
  assign in_edge = in_hs_req & ~in_req_d_r;
  assign out_done = out_hs_ack & ~out_ack_d_r;
  assign tmr_zero = ctl_r[`VPIO_CTL_TMR_EN] && (count_r == {TMR_W{1'b0}});
  assign ctl_wr = wr_stb && (reg_sel == 6'h00);
  // four port sources: input full, output empty, input overrun, output underrun
  assign port_set = {out_done & ~out_hs_req, in_edge & port_pend_r[0], out_done, in_edge};
  // vector table, four port then one timer
  generate
    for (g = 0; g < 4; g = g + 1)
    begin : g_src
      localparam [1:0] SRC_ID = g;
      assign port_clr[g] = (iack_port && port_src == SRC_ID) || (rd_stb && reg_sel == 6'h01 && g == 0);
    end
  endgenerate
  assign port_irq = |port_pend_r;
  assign tmr_irq = tmr_pend_r;
  assign port_src = port_pend_r[0] ? 2'h0 : port_pend_r[1] ? 2'h1 : port_pend_r[2] ? 2'h2 : 2'h3;
  assign port_vec = vec_r[port_src];
  assign tmr_vec = vec_r[4];
  always @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      ctl_r <= 8'h00;
      in_latch_r <= 8'h00;
      out_data <= 8'h00;
      out_hs_req <= 1'b0;
      in_hs_ack <= 1'b0;
      preload_r <= {TMR_W{1'b0}};
      count_r <= {TMR_W{1'b0}};
      tmr_pend_r <= 1'b0;
      port_pend_r <= 4'h0;
      in_req_d_r <= 1'b0;
      out_ack_d_r <= 1'b0;
      for (i = 0; i < 5; i = i + 1)
        vec_r[i] <= `VPIO_VEC_RST;
    end
    else
    begin
      in_req_d_r <= in_hs_req;
      out_ack_d_r <= out_hs_ack;
      if (ctl_wr)
        ctl_r <= wdata;
      // input port latch and handshake
      if (in_edge)
        in_latch_r <= in_data;
      in_hs_ack <= in_hs_req;
      // output port write and handshake
      if (wr_stb && reg_sel == 6'h02)
        out_data <= wdata;
      // request set wins over this unit's own out_done
      if (reg_sel == 6'h02 && (ctl_r[`VPIO_CTL_OUT_HS] ? ext_strobe : wr_stb))
        out_hs_req <= 1'b1;
      else if (out_done)
        out_hs_req <= 1'b0;
      // set wins over clear
      port_pend_r <= (port_pend_r & ~port_clr) | port_set;
      // 24-bit timer
      if (wr_stb && reg_sel >= 6'h04 && reg_sel <= 6'h06)
      begin
        if (reg_sel == 6'h04)
          preload_r[7:0] <= wdata;
        if (reg_sel == 6'h05)
          preload_r[15:8] <= wdata;
        if (reg_sel == 6'h06)
          preload_r[TMR_W-1:16] <= wdata[TMR_W-17:0];
      end
      if (ctl_wr && wdata[`VPIO_CTL_TMR_EN] && !ctl_r[`VPIO_CTL_TMR_EN])
        count_r <= preload_r;
      else if (tmr_zero)
        count_r <= preload_r;
      else if (ctl_r[`VPIO_CTL_TMR_EN])
        count_r <= count_r - {{(TMR_W-1){1'b0}}, 1'b1};
      if (tmr_zero)
        tmr_pend_r <= 1'b1;
      else if (iack_tmr || (wr_stb && reg_sel == 6'h07))
        tmr_pend_r <= 1'b0;
      // host-programmable vectors
      if (wr_stb && reg_sel >= 6'h08 && reg_sel <= 6'h0C)
        vec_r[reg_sel[2:0] ^ 3'h0] <= wdata;
    end
  end
  // every register read directly except preload_r; its addresses return count_r
  always @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      rdata <= 8'h00;
    else if (rd_stb)
    begin
      case (reg_sel)
        6'h00: rdata <= ctl_r;
        6'h01: rdata <= in_latch_r;
        6'h02: rdata <= out_data;
        6'h03: rdata <= {2'h0, out_hs_req, in_hs_req, port_pend_r};
        6'h04: rdata <= count_r[7:0];
        6'h05: rdata <= count_r[15:8];
        6'h06: rdata <= count_r[TMR_W-1:16];
        6'h07: rdata <= {7'h00, tmr_pend_r};
        6'h08, 6'h09, 6'h0A, 6'h0B, 6'h0C: rdata <= vec_r[reg_sel[2:0]];
        default: rdata <= 8'h00;
      endcase
    end
  end
endmodule

// [dv/vpio_glue_properties.sv]
// checker: bus handshake, refusal, interrupt level, input handshake
// assumes straps static while the bus is busy
`timescale 1ns/10ps
`include "vpio_map.vh"
module vpio_chk #(
  parameter NUNIT = 4
) (
  input wire clk,
  input wire resetn,
  input wire [23:9] base_addr,
  input wire a16_mode,
  input wire [2:0] irq_level,
  input wire [23:1] vme_addr,
  input wire [5:0] vme_am,
  input wire vme_as_n,
  input wire vme_ds0_n,
  input wire vme_write_n,
  input wire vme_iack_n,
  input wire [3:1] vme_iack_level,
  input wire vme_data_oe,
  input wire vme_dtack_n,
  input wire [7:1] vme_irq_n,
  input wire [NUNIT-1:0] in_hs_req,
  input wire [NUNIT-1:0] in_hs_ack
);
  wire at = !a16_mode && vme_iack_n && !vme_ds0_n;
  wire hit = at && vme_am == `VPIO_AM_A24_STD && vme_addr[23:9] == base_addr;
  wire miss = at && vme_addr[23:9] != base_addr;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  property p_ack;
    $fell(vme_as_n) && hit |-> ##[2:3] !vme_dtack_n;
  endproperty
  a_ack: assert property (p_ack) else $error("ack late");
  property p_miss;
    !vme_as_n && miss |-> vme_dtack_n;
  endproperty
  a_miss: assert property (p_miss) else $error("foreign ack");
  property p_idle;
    vme_as_n && $past(vme_as_n) |-> vme_dtack_n && !vme_data_oe;
  endproperty
  a_idle: assert property (p_idle) else $error("ack held");
  property p_rdoe;
    !vme_dtack_n && vme_write_n |-> vme_data_oe;
  endproperty
  a_rdoe: assert property (p_rdoe) else $error("read not driven");
  property p_wroe;
    !vme_dtack_n && !vme_write_n |-> !vme_data_oe;
  endproperty
  a_wroe: assert property (p_wroe) else $error("write driven");
  property p_lvl;
    (vme_irq_n | (7'h01 << (irq_level - 3'h1))) == 7'h7f;
  endproperty
  a_lvl: assert property (p_lvl) else $error("wrong level");
  property p_iack;
    !vme_iack_n && vme_iack_level != irq_level |-> vme_dtack_n;
  endproperty
  a_iack: assert property (p_iack) else $error("foreign iack");
  property p_hs;
    $past(resetn) |-> in_hs_ack == $past(in_hs_req);
  endproperty
  a_hs: assert property (p_hs) else $error("handshake lag");
  cover property ($fell(vme_as_n) && hit);
  cover property (!vme_iack_n && !vme_dtack_n);
  cover property (vme_irq_n != 7'h7f);
endmodule
bind vpio_glue vpio_chk #(.NUNIT(NUNIT)) u_chk (.clk(clk), .resetn(resetn), .base_addr(base_addr),
  .a16_mode(a16_mode), .irq_level(irq_level), .vme_addr(vme_addr), .vme_am(vme_am), .vme_as_n(vme_as_n),
  .vme_ds0_n(vme_ds0_n), .vme_write_n(vme_write_n), .vme_iack_n(vme_iack_n), .vme_iack_level(vme_iack_level),
  .vme_data_oe(vme_data_oe), .vme_dtack_n(vme_dtack_n), .vme_irq_n(vme_irq_n), .in_hs_req(in_hs_req),
  .in_hs_ack(in_hs_ack));

// [dv/vpio_host.sv]
// host bus master model: slave cycles and interrupt acknowledge
// assumes cyc is called between cycles only
`timescale 1ns/10ps
module vpio_host (
  // clock and answer
  input wire clk,
  input wire vme_dtack_n,
  input wire [15:0] vme_data_out,
  // request
  output reg [23:1] vme_addr = 23'h0,
  output reg [5:0] vme_am = 6'h0,
  output reg vme_as_n = 1'b1,
  output reg vme_ds0_n = 1'b1,
  output reg vme_ds1_n = 1'b1,
  output reg vme_write_n = 1'b1,
  output reg vme_iack_n = 1'b1,
  output reg [3:1] vme_iack_level = 3'h0,
  output reg [15:0] vme_data_in = 16'h0
);
  // held until ack or 12 edges
  task cyc(input w, input ia, input [23:1] a, input [5:0] m, input [1:0] ds, input [15:0] wd,
    output [15:0] rd, output ok);
    integer n;
    @(negedge clk);
    vme_addr = a;
    vme_am = m;
    vme_iack_level = a[3:1];
    vme_write_n = !w;
    vme_iack_n = !ia;
    vme_data_in = wd;
    vme_as_n = 1'b0;
    vme_ds0_n = !ds[0];
    vme_ds1_n = !ds[1];
    ok = 1'b0;
    rd = 16'h0;
    for (n = 0; n < 12 && !ok; n = n + 1)
    begin
      @(posedge clk);
      if (vme_dtack_n === 1'b0)
      begin
        ok = 1'b1;
        rd = vme_data_out;
      end
    end
    @(negedge clk);
    vme_as_n = 1'b1;
    vme_ds0_n = 1'b1;
    vme_ds1_n = 1'b1;
    vme_iack_n = 1'b1;
    vme_data_in = ~wd;
    @(posedge clk);
  endtask
endmodule

// [dv/vpio_tb.sv]
// self-checking bench for the bus-side glue
// assumes vpio_host drives the bus, the bench the ports
`timescale 1ns/10ps
`include "vpio_map.vh"
module testbench;
  localparam [23:9] BASE = 15'h1234;
  reg clk, resetn, a16, pair, ok;
  reg [31:0] ind;
  reg [3:0] inr, oack;
  reg [15:0] rd;
  wire [23:1] ad;
  wire [5:0] am;
  wire as_n, ds0_n, ds1_n, wr_n, ia_n, oe, dt_n;
  wire [3:1] il;
  wire [15:0] di, dq;
  wire [7:1] irq_n;
  wire [3:0] iack, oreq;
  wire [31:0] od;
  integer fails, num_checks;
  vpio_glue dut (.clk(clk), .resetn(resetn), .base_addr(BASE), .a16_mode(a16), .irq_level(3'h5),
    .pair_mode(pair), .vme_addr(ad), .vme_am(am), .vme_as_n(as_n), .vme_ds0_n(ds0_n), .vme_ds1_n(ds1_n),
    .vme_write_n(wr_n), .vme_iack_n(ia_n), .vme_iack_level(il), .vme_data_in(di), .vme_data_out(dq),
    .vme_data_oe(oe), .vme_dtack_n(dt_n), .vme_irq_n(irq_n), .in_data(ind), .in_hs_req(inr),
    .in_hs_ack(iack), .out_data(od), .out_hs_req(oreq), .out_hs_ack(oack));
  vpio_host h (.clk(clk), .vme_dtack_n(dt_n), .vme_data_out(dq), .vme_addr(ad), .vme_am(am),
    .vme_as_n(as_n), .vme_ds0_n(ds0_n), .vme_ds1_n(ds1_n), .vme_write_n(wr_n), .vme_iack_n(ia_n),
    .vme_iack_level(il), .vme_data_in(di));
  ////////////////////////////////////////
  task print_verdict;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task chk(input [15:0] g, input [15:0] e);
    num_checks = num_checks + 1;
    if (g !== e)
    begin
      fails = fails + 1;
      $display("MISMATCH %0t got %h exp %h", $time, g, e);
    end
  endtask
  task acc(input w, input u, input [5:0] r, input [1:0] ds, input [15:0] d);
    h.cyc(w, 1'b0, {BASE, 1'b0, u, r}, `VPIO_AM_A24_STD, ds, d, rd, ok);
    chk({15'h0, ok}, 16'h1);
    if (ok !== 1'b1)
      print_verdict;
  endtask
  task wirq(input integer n, input b);
    while (irq_n[5] !== b && n > 0)
    begin
      @(negedge clk);
      n = n - 1;
    end
    chk({15'h0, irq_n[5]}, {15'h0, b});
    if (irq_n[5] !== b)
      print_verdict;
  endtask
  task iak(input [2:0] lv);
    h.cyc(1'b0, 1'b1, {20'h0, lv}, 6'h0, 2'h1, 16'h0, rd, ok);
  endtask
  ////////////////////////////////////////
  task t_vec;
    integer r, u;
    for (u = 0; u < 2; u = u + 1)
      for (r = 8; r < 13; r = r + 1)
      begin
        acc(0, u[0], r[5:0], 2'h3, 16'h0);
        chk(rd, {2{`VPIO_VEC_RST}});
        acc(1, u[0], r[5:0], 2'h3, {3'h4, u[0], r[3:0], 3'h3, u[0], r[3:0]});
        acc(0, u[0], r[5:0], 2'h3, 16'h0);
        chk(rd, {3'h4, u[0], r[3:0], 3'h3, u[0], r[3:0]});
      end
    acc(1, 1, 8, 2'h1, 16'h33c7);
    acc(0, 1, 8, 2'h3, 16'h0);
    chk(rd, 16'h98c7);
    $display("vec done");
  endtask
  task t_in;
    @(negedge clk);
    ind[15:8] = 8'h5a;
    inr[1] = 1'b1;
    @(negedge clk);
    chk({15'h0, iack[1]}, 16'h1);
    inr[1] = 1'b0;
    wirq(20, 1'b0);
    iak(3'h4);
    chk({15'h0, ok}, 16'h0);
    iak(3'h5);
    chk({7'h0, ok, rd[7:0]}, 16'h01c7);
    wirq(8, 1'b1);
    acc(0, 1, 1, 2'h1, 16'h0);
    chk({8'h0, rd[7:0]}, 16'h005a);
    $display("in done");
  endtask
  task t_tmr;
    integer r;
    for (r = 4; r < 7; r = r + 1)
      acc(1, 1, r[5:0], 2'h2, 16'h0100);
    acc(1, 1, 0, 2'h2, 16'h0100);
    wirq(70000, 1'b0);
    iak(3'h5);
    chk({8'h0, rd[7:0]}, 16'h009c);
    acc(1, 1, 0, 2'h2, 16'h0);
    acc(1, 1, 7, 2'h2, 16'hff00);
    wirq(8, 1'b1);
    $display("tmr done");
  endtask
  task t_out;
    @(negedge clk);
    pair = 1'b1;
    acc(1, 0, 0, 2'h2, 16'h0200);
    acc(1, 0, 2, 2'h3, 16'hbeef);
    @(negedge clk);
    chk({od[23:16], od[7:0]}, 16'hbeef);
    chk({14'h0, oreq[2], oreq[0]}, 16'h3);
    oack = 4'h5;
    @(negedge clk);
    oack = 4'h0;
    chk({14'h0, oreq[2], oreq[0]}, 16'h0);
    pair = 1'b0;
    acc(1, 0, 2, 2'h3, 16'h1234);
    chk({14'h0, oreq[2], oreq[0]}, 16'h1);
    $display("out done");
  endtask
  task t_miss;
    h.cyc(1'b0, 1'b0, {BASE + 15'h1, 8'h08}, `VPIO_AM_A24_STD, 2'h3, 16'h0, rd, ok);
    chk({15'h0, ok}, 16'h0);
    h.cyc(1'b0, 1'b0, {BASE, 8'h08}, 6'h3e, 2'h3, 16'h0, rd, ok);
    chk({15'h0, ok}, 16'h0);
    @(negedge clk);
    a16 = 1'b1;
    h.cyc(1'b0, 1'b0, {8'h0, BASE[15:9], 8'h08}, `VPIO_AM_A16_STD, 2'h3, 16'h0, rd, ok);
    chk(rd, 16'h8868);
    @(negedge clk);
    a16 = 1'b0;
    $display("miss done");
  endtask
  ////////////////////////////////////////
  initial
  begin
    clk = 1'b0;
    forever
      #10 clk = ~clk;
  end
  initial
  begin
    {resetn, a16, pair, ok, ind, inr, oack, rd} = 0;
    fails = 0;
    num_checks = 0;
    repeat (2) @(posedge clk);
    @(negedge clk);
    resetn = 1'b1;
    t_vec;
    t_in;
    t_tmr;
    t_out;
    t_miss;
    print_verdict;
  end
endmodule
